//--- common/twm_defs.svh
/*
  Constants of the two-wire master transmitter: control bit positions,
  status codes and bus timing.
  Assumes it is included once per compile unit by its bare name.
*/
`ifndef TWM_DEFS_SVH
`define TWM_DEFS_SVH

// ----------------------------------------------------------------
// Control register bit positions
// ----------------------------------------------------------------
`define TWM_CTL_INT 7
`define TWM_CTL_EA 6
`define TWM_CTL_STA 5
`define TWM_CTL_STO 4
`define TWM_CTL_WC 3
`define TWM_CTL_EN 2
`define TWM_CTL_IE 0

// ----------------------------------------------------------------
// Status codes (prescaler bits zero) and status layout
// ----------------------------------------------------------------
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_ADDR_ACK 8'h18
`define TWM_ST_ADDR_NACK 8'h20
`define TWM_ST_DATA_ACK 8'h28
`define TWM_ST_DATA_NACK 8'h30
`define TWM_ST_ARB_LOST 8'h38
`define TWM_ST_NO_INFO 8'hF8
`define TWM_ST_CODE_MASK 8'hF8
`define TWM_PRESC_W 2

// ----------------------------------------------------------------
// Timing: one quarter of a bus bit time, and the system clock period
// ----------------------------------------------------------------
`define TWM_QUARTER_NS 2500
`define TWM_CLK_NS 50
`define TWM_ACK_BIT 4'h8

`endif

//--- common/twm_pkg.sv
/*
  Types shared by the two-wire master transmitter.
  Assumes nothing of its surroundings.
*/
package twm_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    TWM_IDLE,
    TWM_WAIT_FREE,
    TWM_RESTART,
    TWM_START,
    TWM_HOLD,
    TWM_BIT,
    TWM_STOP
  } twm_state_e;
endpackage

//--- rtl/twm_sync.sv
/*
  Two flip-flop synchroniser for a group of independent levels.
  Assumes each bit is a slow level; no bus coherency between bits.
*/
`timescale 1ns/1ns
`default_nettype none
module twm_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("twm_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta;

  // ----------------------------------------------------------------
  // Two stages; idle bus lines are high, so reset to ones
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule
`default_nettype wire

//--- rtl/twm_master_tx.sv
/*
  Master-transmitter sequencer of a byte-oriented two-wire serial bus:
  control, status and data registers on direct register ports, START,
  address and data bytes with acknowledge, repeated START and STOP.
  Assumes the bus lines are open drain with external pull-ups and that
  the register ports are driven from logic on clk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "twm_defs.svh"

// How it works
// - No bus activity while interface enable low
// - Writing one to completion flag clears it
// - START driven only once bus is free
// - After START, flag set, status 08
// - After address and acknowledge, flag set, 18/20/38
// - Data byte shifted out, acknowledge taken, flag set
// - Flag clear with stop request drives STOP
// - Data write while flag low discarded, collision set
// - Start request mid-transfer gives repeated START, 10
module twm_master_tx
  import twm_pkg::*;
#(
  parameter int QUARTER_CYC = (`TWM_QUARTER_NS + `TWM_CLK_NS - 1) / `TWM_CLK_NS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register ports
  input wire logic ctrl_we,
  input wire logic status_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  output logic [7:0] bus_control,
  output logic [7:0] bus_status_reg,
  output logic [7:0] bus_data_reg,
  output logic irq,
  // Two-wire bus, open drain
  input wire logic scl_in,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_o,
  output logic sda_oe
);
  generate
    if (QUARTER_CYC < 1 || QUARTER_CYC > 65535) begin : g_bad_quarter
      $error("twm_master_tx: QUARTER_CYC out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic int_flag; // Completion flag
  logic ack_enable; // Stored only; no effect when transmitting
  logic start_request;
  logic stop_request;
  logic write_collision_flag;
  logic iface_en; // Interface enable
  logic irq_enable;
  logic [`TWM_PRESC_W-1:0] presc; // Prescaler bits of status
  logic [7:0] status_code; // Bus state code, low bits zero
  twm_state_e state;
  logic [15:0] qcnt; // Quarter-bit timer
  logic [1:0] phase; // Quarter within the current bit
  logic [3:0] bitn; // Bit index, 8 is the acknowledge slot
  logic [7:0] shreg; // Byte being shifted out
  logic first_byte; // Next byte is the address byte
  logic own; // This master holds the bus
  logic ack_seen;
  logic done; // One-cycle pulse: step complete
  logic stop_done; // One-cycle pulse: STOP finished
  logic bus_busy; // A START seen on the bus, this master's own included, without a STOP
  logic sda_prev;
  logic scl_s;
  logic sda_s;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic flag_clear_wr = ctrl_we & wdata[`TWM_CTL_INT];
  wire logic hold_go = ~int_flag & ~done & iface_en;
  // Released clock still read low: a slave stretches, or the synchroniser lags
  wire logic stretched = ((phase == 2'h1) | (phase == 2'h2)) & ~scl_oe & ~scl_s;
  wire logic tick = (qcnt == 16'(QUARTER_CYC - 1)) & ~stretched;
  wire logic data_wr_ok = data_we & int_flag;
  wire logic start_seen = scl_s & sda_prev & ~sda_s;
  wire logic stop_seen = scl_s & ~sda_prev & sda_s;
  wire logic last_ph = tick & (phase == 2'h3);
  wire logic [7:0] addr_code = ack_seen ? `TWM_ST_ADDR_ACK : `TWM_ST_ADDR_NACK;
  wire logic [7:0] data_code = ack_seen ? `TWM_ST_DATA_ACK : `TWM_ST_DATA_NACK;
  wire logic arb_lost = (state == TWM_BIT) & tick & (phase == 2'h2) &
                        (bitn != `TWM_ACK_BIT) & shreg[7] & ~sda_s;

  // Register readback, all fields are flops
  assign bus_control = {int_flag, ack_enable, start_request, stop_request,
                        write_collision_flag, iface_en, 1'b0, irq_enable};
  assign bus_status_reg = {status_code[7:3], 1'b0, presc};

  // ----------------------------------------------------------------
  // Bus line synchroniser
  // ----------------------------------------------------------------
  twm_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({scl_in, sda_in}),
    .sync_out({scl_s, sda_s})
  );

  // ----------------------------------------------------------------
  // Control fields; hardware clear of stop after STOP
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_enable <= 1'b0;
      start_request <= 1'b0;
      stop_request <= 1'b0;
      iface_en <= 1'b0;
      irq_enable <= 1'b0;
    end else if (ctrl_we) begin
      ack_enable <= wdata[`TWM_CTL_EA];
      start_request <= wdata[`TWM_CTL_STA];
      stop_request <= wdata[`TWM_CTL_STO];
      iface_en <= wdata[`TWM_CTL_EN];
      irq_enable <= wdata[`TWM_CTL_IE];
    end else if (stop_done) begin
      stop_request <= 1'b0; // Stop bit self-clears once STOP is on the bus
    end
  end

  // ----------------------------------------------------------------
  // Completion flag: a hardware set wins over a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_flag <= 1'b0;
    end else if (done) begin
      int_flag <= 1'b1;
    end else if (flag_clear_wr) begin
      int_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Data register and write collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      bus_data_reg <= 8'h00;
      write_collision_flag <= 1'b0;
    end else if (data_wr_ok) begin
      bus_data_reg <= wdata;
      write_collision_flag <= 1'b0; // A good write clears the collision
    end else if (data_we) begin
      write_collision_flag <= 1'b1; // Write discarded
    end
  end

  // ----------------------------------------------------------------
  // Status prescaler bits, and interrupt request
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      presc <= '0;
      irq <= 1'b0;
    end else begin
      if (status_we) begin
        presc <= wdata[`TWM_PRESC_W-1:0]; // Low bits are not bus state
      end
      irq <= irq_enable & int_flag;
    end
  end

  // ----------------------------------------------------------------
  // Bus-free monitor; START sets busy, STOP clears it
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sda_prev <= 1'b1;
      bus_busy <= 1'b0;
    end else begin
      sda_prev <= sda_s;
      if (start_seen) begin
        bus_busy <= 1'b1;
      end else if (stop_seen) begin
        bus_busy <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Quarter timer; holds while a slave stretches the clock low
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      qcnt <= 16'h0000;
    end else if (tick || state == TWM_IDLE || state == TWM_HOLD ||
                 state == TWM_WAIT_FREE) begin
      qcnt <= 16'h0000;
    end else if (!stretched) begin
      qcnt <= qcnt + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer. Lines are pulled low while the enables are high.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= TWM_IDLE;
      phase <= 2'h0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      first_byte <= 1'b0;
      own <= 1'b0;
      ack_seen <= 1'b0;
      done <= 1'b0;
      stop_done <= 1'b0;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      status_code <= `TWM_ST_NO_INFO;
    end else begin
      done <= 1'b0;
      stop_done <= 1'b0;
      if (tick) begin
        phase <= phase + 2'h1;
      end
      if (!iface_en) begin
        // Disabled: release the bus and forget ownership
        state <= TWM_IDLE;
        own <= 1'b0;
        scl_oe <= 1'b0;
        sda_oe <= 1'b0;
        phase <= 2'h0;
      end else begin
        unique case (state)
          TWM_IDLE: begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            phase <= 2'h0;
            if (hold_go && start_request) begin
              state <= TWM_WAIT_FREE;
            end
          end
          TWM_WAIT_FREE: begin
            phase <= 2'h0;
            if (!bus_busy) begin
              state <= TWM_START; // Waits as long as another master holds it
            end
          end
          TWM_RESTART: begin
            // Release data with clock low, then release clock
            sda_oe <= 1'b0;
            if (tick && phase == 2'h0) begin
              scl_oe <= 1'b0;
            end
            if (last_ph) begin
              state <= TWM_START;
            end
          end
          TWM_START: begin
            if (tick && phase == 2'h0) begin
              sda_oe <= 1'b1; // Data falls while clock high
            end
            if (tick && phase == 2'h2) begin
              scl_oe <= 1'b1;
            end
            if (last_ph) begin
              status_code <= own ? `TWM_ST_RSTART : `TWM_ST_START;
              own <= 1'b1;
              first_byte <= 1'b1;
              done <= 1'b1;
              state <= TWM_HOLD;
            end
          end
          TWM_HOLD: begin
            // Clock held low until software clears the flag
            scl_oe <= 1'b1;
            phase <= 2'h0;
            bitn <= 4'h0;
            if (hold_go) begin
              if (stop_request) begin
                state <= TWM_STOP;
              end else if (start_request) begin
                state <= TWM_RESTART;
              end else begin
                shreg <= bus_data_reg;
                state <= TWM_BIT;
              end
            end
          end
          TWM_BIT: begin
            // Data moves a full quarter before the clock is released, so a
            // data edge never lands with a clock edge and reads as START or STOP
            if (tick && phase == 2'h0) begin
              sda_oe <= (bitn == `TWM_ACK_BIT) ? 1'b0 : ~shreg[7];
            end
            if (tick && phase == 2'h1) begin
              scl_oe <= 1'b0;
            end
            if (tick && phase == 2'h2 && bitn == `TWM_ACK_BIT) begin
              ack_seen <= ~sda_s;
            end
            if (arb_lost) begin
              // Another master drove low while this one sent a one
              status_code <= `TWM_ST_ARB_LOST;
              scl_oe <= 1'b0;
              sda_oe <= 1'b0;
              own <= 1'b0;
              done <= 1'b1;
              state <= TWM_IDLE;
            end else if (last_ph) begin
              scl_oe <= 1'b1;
              shreg <= {shreg[6:0], 1'b0};
              bitn <= bitn + 4'h1;
              if (bitn == `TWM_ACK_BIT) begin
                status_code <= first_byte ? addr_code : data_code;
                first_byte <= 1'b0;
                done <= 1'b1;
                state <= TWM_HOLD;
              end
            end
          end
          TWM_STOP: begin
            if (tick && phase == 2'h0) begin
              sda_oe <= 1'b1; // Data low while clock still low
            end
            if (tick && phase == 2'h1) begin
              scl_oe <= 1'b0;
            end
            if (tick && phase == 2'h2) begin
              sda_oe <= 1'b0; // Data rises while clock high
            end
            if (last_ph) begin
              own <= 1'b0;
              stop_done <= 1'b1;
              status_code <= `TWM_ST_NO_INFO;
              state <= start_request ? TWM_WAIT_FREE : TWM_IDLE;
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- verification/twm_chk.sv
/*
  Checker for the two-wire master transmitter, bound to its ports.
  Assumes one clock domain and the register port contract.
*/
`timescale 1ns/1ns
`default_nettype none
module twm_chk #(
  parameter int QUARTER_CYC = 50
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register ports
  input wire logic ctrl_we,
  input wire logic status_we,
  input wire logic data_we,
  input wire logic [7:0] wdata,
  input wire logic [7:0] bus_control,
  input wire logic [7:0] bus_status_reg,
  input wire logic [7:0] bus_data_reg,
  input wire logic irq,
  // Bus
  input wire logic scl_in,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // ----------------------------------------------------------------
  // Bus step bounds
  // ----------------------------------------------------------------
  // Two bit times with margin; a START or STOP step never takes longer without stretching
  localparam int WAIT_MAX = 8 * QUARTER_CYC + 8;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Own START: data pulled while the clock stayed released
  sequence s_start;
    $rose(sda_oe) && !scl_oe && !$past(scl_oe);
  endsequence
  property p_dis_drop;
    ctrl_we && !wdata[2] |=> ##1 !sda_oe && !scl_oe;
  endproperty
  a_dis_drop: assert property (p_dis_drop) else $error("bus held while disabled");
  property p_flag_clr;
    ctrl_we && wdata[7] && bus_control[7] |=> !bus_control[7];
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag not cleared");
  property p_start_free;
    s_start |-> $past(sda_in);
  endproperty
  a_start_free: assert property (p_start_free) else $error("start on busy bus");
  property p_start_code;
    s_start |-> ##[1:WAIT_MAX] $rose(bus_control[7]) && bus_status_reg[7:3] inside {5'h01, 5'h02};
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code");
  property p_irq;
    irq == $past(bus_control[7] & bus_control[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_wcol;
    data_we && !bus_control[7] |=> bus_control[3] && $stable(bus_data_reg);
  endproperty
  a_wcol: assert property (p_wcol) else $error("collision not flagged");
  property p_data_ok;
    data_we && bus_control[7] |=> bus_data_reg == $past(wdata) && !bus_control[3];
  endproperty
  a_data_ok: assert property (p_data_ok) else $error("data write lost");
  property p_hold_scl;
    bus_control[7] && bus_control[2] && scl_oe && !ctrl_we |=> scl_oe;
  endproperty
  a_hold_scl: assert property (p_hold_scl) else $error("clock released early");
  property p_stop;
    ctrl_we && (wdata & 8'hB4) == 8'h94 && bus_control[7] |-> ##[1:WAIT_MAX]
      !bus_control[4] && !sda_oe && !scl_oe && bus_status_reg[7:3] == 5'h1F;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not finished");
  property p_presc;
    status_we |=> bus_status_reg[1:0] == $past(wdata[1:0]) && !bus_status_reg[2];
  endproperty
  a_presc: assert property (p_presc) else $error("prescaler bits");
  c_rstart: cover property ($rose(bus_control[7]) && bus_status_reg[7:3] == 5'h02);
  c_dnack: cover property ($rose(bus_control[7]) && bus_status_reg[7:3] == 5'h06);
  c_arb: cover property ($rose(bus_control[7]) && bus_status_reg[7:3] == 5'h07);
endmodule
bind twm_master_tx twm_chk #(.QUARTER_CYC(QUARTER_CYC)) twm_chk_i (.clk(clk), .resetn(resetn),
  .ctrl_we(ctrl_we), .status_we(status_we), .data_we(data_we), .wdata(wdata),
  .bus_control(bus_control), .bus_status_reg(bus_status_reg), .bus_data_reg(bus_data_reg),
  .irq(irq), .scl_in(scl_in), .scl_o(scl_o), .scl_oe(scl_oe), .sda_in(sda_in),
  .sda_o(sda_o), .sda_oe(sda_oe));
`default_nettype wire

//--- verification/twm_slave.sv
/*
  Behavioural slave on the two-wire bus: takes bytes MSB first, answers
  acknowledge or not, may stretch the clock.
  Assumes open-drain lines with pull-ups resolved by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module twm_slave (
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Behaviour controls
  input wire logic nack,
  input wire logic stretch,
  // Pulls onto the lines
  output var logic scl_pull,
  output var logic sda_pull
);
  logic [7:0] shift_byte = 8'h00; // Bits taken so far
  int bit_cnt = 0; // Clock rises in this byte
  bit active = 1'b0; // Between START and STOP
  logic [7:0] got[$]; // Bytes taken, read by the bench
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // START or repeated START restarts the byte
  always @(negedge sda) if (scl) begin
    active = 1'b1;
    bit_cnt = 0;
  end
  // STOP ends the frame
  always @(posedge sda) if (scl) active = 1'b0;
  // Data taken on the rising clock, MSB first
  always @(posedge scl) if (active) begin
    if (bit_cnt < 8) shift_byte = {shift_byte[6:0], sda};
    if (bit_cnt == 7) got.push_back(shift_byte);
    bit_cnt++;
  end
  // Acknowledge slot lasts one bit; released after it so no stale low stays
  always @(negedge scl) if (active) begin
    if (bit_cnt == 8) sda_pull = !nack;
    else if (bit_cnt == 9) begin
      sda_pull = 1'b0;
      bit_cnt = 0;
    end
  end
  // Slow answer: hold the clock low after each fall, longer than the
  // master's own low half so that the stretch is really seen
  always @(negedge scl) if (stretch) begin
    scl_pull = 1'b1;
    #600 scl_pull = 1'b0;
  end
endmodule
`default_nettype wire

//--- verification/test_two_wire_master_transmit.sv
/*
  Bench for the two-wire master transmitter with a slave model.
  Assumes open-drain lines with pull-ups and a 50 ns clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_two_wire_master_transmit;
  // ----------------------------------------------------------------
  // Stimulus, lines and model state
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ctrl_we = 1'b0;
  logic status_we = 1'b0;
  logic data_we = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic nack = 1'b0;
  logic stretch = 1'b0;
  logic ext_scl = 1'b0; // Second master pulls
  logic ext_sda = 1'b0;
  logic [7:0] bc, bs, bd;
  logic irq, scl_o, scl_oe, sda_o, sda_oe, s_scl, s_sda;
  wire logic scl = !(scl_oe | s_scl | ext_scl);
  wire logic sda = !(sda_oe | s_sda | ext_sda);
  int num_errors = 0;
  int check_count = 0;
  bit first = 1'b0; // Next byte is an address
  logic [7:0] sent[$]; // Bytes the slave must hold
  logic [7:0] r;
  initial begin
    forever #25 clk = ~clk;
  end
  twm_master_tx #(.QUARTER_CYC(4)) twm_master_tx_i (.clk(clk), .resetn(resetn),
    .ctrl_we(ctrl_we), .status_we(status_we), .data_we(data_we), .wdata(wdata),
    .bus_control(bc), .bus_status_reg(bs), .bus_data_reg(bd), .irq(irq),
    .scl_in(scl), .scl_o(scl_o), .scl_oe(scl_oe), .sda_in(sda), .sda_o(sda_o),
    .sda_oe(sda_oe));
  twm_slave twm_slave_i (.scl(scl), .sda(sda), .nack(nack), .stretch(stretch),
    .scl_pull(s_scl), .sda_pull(s_sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (num_errors == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Register write: 0 control, 1 status, 2 data
  task automatic wr(input int sel, input logic [7:0] v);
    @(negedge clk);
    wdata = v;
    ctrl_we = (sel == 0);
    status_we = (sel == 1);
    data_we = (sel == 2);
    @(negedge clk);
    ctrl_we = 1'b0;
    status_we = 1'b0;
    data_we = 1'b0;
  endtask
  // Bounded wait for the completion flag
  task automatic wflag;
    for (int n = 0; bc[7] !== 1'b1; n++) begin
      if (n == 2000) begin
        num_errors++;
        results;
      end
      @(negedge clk);
    end
  endtask
  // Control write, colliding data write, then the step's status code
  task automatic step(input logic [7:0] ctl, input logic [7:0] code);
    wr(0, ctl);
    chk(bc & 8'h80, 8'h00);
    r = bd;
    wr(2, ~r);
    chk(bc & 8'h08, 8'h08);
    chk(bd, r);
    wflag;
    chk(bs & 8'hF8, code);
  endtask
  // Load a byte and send it; the code follows address or data and the answer
  task automatic send(input logic [7:0] b, input logic nk);
    nack = nk;
    wr(2, b);
    chk(bc & 8'h08, 8'h00);
    sent.push_back(b);
    step(8'h84, 8'h18 + {nk, 3'b000} + {!first, 4'b0000});
    first = 1'b0;
  endtask
  initial begin
    void'($urandom(32'h548645ef));
    #100 resetn = 1'b1;
    chk(bc, 8'h00);
    chk(bs, 8'hF8);
    chk(bd, 8'h00);
    chk({7'h00, irq}, 8'h00);
    wr(1, 8'h03);
    chk(bs, 8'hFB);
    wr(0, 8'hA0);
    repeat (40) @(negedge clk);
    chk({6'h00, sda_oe, scl_oe}, 8'h00);
    // Another master owns the bus until its STOP
    ext_sda = 1'b1;
    #100 ext_scl = 1'b1;
    wr(0, 8'hA5);
    repeat (60) @(negedge clk);
    chk({7'h00, sda_oe}, 8'h00);
    ext_scl = 1'b0;
    #100 ext_sda = 1'b0;
    wflag;
    chk(bs & 8'hF8, 8'h08);
    @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    first = 1'b1;
    r = 8'($urandom);
    send({r[7:1], 1'b0}, 1'b0);
    for (int i = 0; i < 3; i++) begin
      stretch = (i == 1);
      r = 8'($urandom);
      send(r, i == 2);
    end
    stretch = 1'b0;
    step(8'hA4, 8'h10);
    first = 1'b1;
    send(8'h5A, 1'b1);
    chk({7'h00, irq}, 8'h00);
    wr(0, 8'h94);
    for (int n = 0; n < 200 && bc[4] !== 1'b0; n++) @(negedge clk);
    if (bc[4] !== 1'b0) begin
      num_errors++; // STOP never finished
      results;
    end
    chk(bc & 8'h90, 8'h00);
    chk({6'h00, sda_oe, scl_oe}, 8'h00);
    chk(bs, 8'hFB);
    chk({7'h00, twm_slave_i.active}, 8'h00);
    // A one sent while another master holds data low loses the bus
    step(8'hA4, 8'h08);
    ext_sda = 1'b1;
    wr(2, 8'h80);
    step(8'h84, 8'h38);
    ext_sda = 1'b0;
    repeat (20) @(negedge clk);
    chk(8'(twm_slave_i.got.size()), 8'(sent.size()));
    while (sent.size() > 0 && twm_slave_i.got.size() > 0) begin
      chk(twm_slave_i.got.pop_front(), sent.pop_front());
    end
    // Dropping enable while the bus is held releases both lines
    step(8'hA4, 8'h08);
    chk({6'h00, sda_oe, scl_oe}, 8'h03);
    wr(0, 8'h00);
    @(negedge clk);
    chk({6'h00, sda_oe, scl_oe}, 8'h00);
    results;
  end
endmodule
`default_nettype wire
